// ### sac_regs.vh
// register offsets, field positions, reset values and timing counts
`ifndef SAC_REGS_VH
`define SAC_REGS_VH
// register offsets on the serial control port (7-bit address)
`define SAC_ADDR_STATUS      7'h01
`define SAC_ADDR_CTRL        7'h0d
`define SAC_ADDR_HS_DRIVE    7'h0e
`define SAC_ADDR_LS_DRIVE    7'h0f
// amplifier control fields
`define SAC_SH_EN_BIT        7
`define SAC_BLK_SEL_BIT      6
`define SAC_BLK_MSB          5
`define SAC_BLK_LSB          3
`define SAC_DIV_BIT          2
`define SAC_GAIN_MSB         1
`define SAC_GAIN_LSB         0
`define SAC_BLK_OFF          3'h0
// reset values
`define SAC_CTRL_RST         8'h01
`define SAC_DRIVE_RST        8'h00
// serial frame layout
`define SAC_FRAME_BITS       5'h10
`define SAC_CMD_BITS         5'h08
`define SAC_RW_BIT           15
// timing: clock rate and gate drive time
`define SAC_CLK_MHZ          100
`define SAC_DRV_TIME_NS      4000
`define SAC_DRV_CYCLES       ((`SAC_DRV_TIME_NS * `SAC_CLK_MHZ) / 1000)
`endif

// ### sac_blank_timer.v
// blanking window and gate drive time supervision
`timescale 1ns/1ps
`default_nettype none
`include "sac_regs.vh"
module sac_blank_timer #(
  parameter DRV_CYCLES = `SAC_DRV_CYCLES,
  parameter CW         = 16
) (
  input  wire          clock_i,
  input  wire          srst_i,
  input  wire          hb1_switch_i,
  input  wire          hb2_switch_i,
  input  wire          source_sel_i,
  input  wire [2:0]    length_code_i,
  input  wire          gate_settled_i,
  output reg           blanking_o,
  output reg           amp_update_o,
  output reg           gate_fault_o
);
  localparam [CW-1:0]  DRV = DRV_CYCLES[CW-1:0];
  localparam [CW+2:0]  DRV_W = {3'h0, DRV};

  reg  [CW-1:0] blank_cnt_q;
  reg  [CW-1:0] drive_cnt_q;
  wire          trig;
  wire [CW+2:0] len_prod;
  wire [CW-1:0] len_cyc;

  // code n gives (n+1) eighths of the drive time, 1 gives 2/8 = 25 %
  assign trig     = source_sel_i ? hb2_switch_i : hb1_switch_i;
  // four-bit sum so code 7 yields eight eighths instead of wrapping to zero
  assign len_prod = DRV_W * {{(CW-1){1'b0}}, {1'b0, length_code_i} + 4'h1};
  assign len_cyc  = len_prod[CW+2:3];

  // blanking counter, restarted by every event of the chosen bridge while the length code is not off
  always @(posedge clock_i) begin
    if (srst_i) begin
      blank_cnt_q  <= {CW{1'b0}};
      blanking_o   <= 1'b0;
      amp_update_o <= 1'b1;
    end else if (trig && length_code_i != `SAC_BLK_OFF) begin
      blank_cnt_q  <= len_cyc - {{(CW-1){1'b0}}, 1'b1};
      blanking_o   <= 1'b1;
      amp_update_o <= 1'b0;
    end else begin
      if (blank_cnt_q != {CW{1'b0}})
        blank_cnt_q <= blank_cnt_q - {{(CW-1){1'b0}}, 1'b1};
      // output updates resume once the window has run out
      blanking_o   <= (blank_cnt_q != {CW{1'b0}});
      amp_update_o <= (blank_cnt_q == {CW{1'b0}});
    end
  end

  // drive time supervision: gate must settle before the timer expires
  always @(posedge clock_i) begin
    if (srst_i) begin
      drive_cnt_q  <= {CW{1'b0}};
      gate_fault_o <= 1'b0;
    end else begin
      gate_fault_o <= 1'b0;
      if (hb1_switch_i)
        drive_cnt_q <= DRV;
      else if (drive_cnt_q != {CW{1'b0}}) begin
        if (gate_settled_i)
          drive_cnt_q <= {CW{1'b0}};
        else begin
          drive_cnt_q <= drive_cnt_q - {{(CW-1){1'b0}}, 1'b1};
          if (drive_cnt_q == {{(CW-1){1'b0}}, 1'b1})
            gate_fault_o <= 1'b1;
        end
      end
    end
  end
endmodule // sac_blank_timer
`default_nettype wire

// ### sac_top.v
// shunt amplifier control register with serial port and blanking
// Summary of operation
// - eight-bit read/write amplifier control register at 0xd, resets to 0x01.
// - bit 7 enables amplifier sample-and-hold; resets to zero.
// - bit 6 picks blanking trigger: zero first, one second half-bridge.
// - bits 5..3 set blanking length; 000 off, 001..111 give 25..100 percent.
// - bit 2 picks reference: zero half, one eighth of analogue supply.
// - bits 1..0 set gain 10, 20, 40, 80; resets to 01.
// - serial variant sets drive currents per side; pin variant sets both.
// - gate fault when gate does not settle within the drive time after a first half-bridge event.
`timescale 1ns/1ps
`default_nettype none
`include "sac_regs.vh"
module sac_top #(
  parameter SERIAL_VARIANT = 1,
  parameter DRV_CYCLES     = `SAC_DRV_CYCLES
) (
  input  wire       clock_i,
  input  wire       srst_i,
  input  wire       spi_sclk_i,
  input  wire       spi_sdi_i,
  input  wire       spi_cs_n_i,
  output reg        spi_sdo_o,
  output reg        spi_sdo_oe_o,
  input  wire [3:0] drive_current_pin_i,
  input  wire       gate_settled_i,
  input  wire       hb1_switch_i,
  input  wire       hb2_switch_i,
  output reg        sample_hold_enable_o,
  output reg        blanking_source_select_o,
  output reg  [2:0] blanking_length_o,
  output reg        reference_divider_select_o,
  output reg  [1:0] amplifier_gain_code_o,
  output reg  [3:0] hs_source_drive_current_o,
  output reg  [3:0] hs_sink_drive_current_o,
  output reg  [3:0] ls_source_drive_current_o,
  output reg  [3:0] ls_sink_drive_current_o,
  output wire       blanking_o,
  output wire       amp_update_o,
  output reg        gate_fault_o
);
  localparam NS = 8; // cs, sclk, sdi, settled, four drive pins

  reg  [NS-1:0] s1_q;
  reg  [NS-1:0] s2_q;
  reg  [NS-1:0] s3_q;
  reg  [NS-1:0] filt_q;
  reg  [NS-1:0] filt_prev_q;
  reg  [7:0]    ctrl_q;
  reg  [7:0]    hs_drv_q;
  reg  [7:0]    ls_drv_q;
  reg  [15:0]   shift_q;
  reg  [7:0]    rd_q;
  reg  [4:0]    bit_cnt_q;
  wire [NS-1:0] raw;
  wire          cs_n;
  wire          sclk_rise;
  wire          sclk_fall;
  wire          cs_fall;
  wire          cs_rise;
  wire [6:0]    rx_addr;
  wire          frame_ok;
  wire          do_write;
  wire          read_status;
  wire          fault_evt;

  // read decode; unmapped addresses answer zero
  function [7:0] rd_mux;
    input [6:0] a;
    input [7:0] c;
    input [7:0] h;
    input [7:0] l;
    input       f;
    begin
      case (a)
        `SAC_ADDR_CTRL:     rd_mux = c;
        `SAC_ADDR_HS_DRIVE: rd_mux = h;
        `SAC_ADDR_LS_DRIVE: rd_mux = l;
        `SAC_ADDR_STATUS:   rd_mux = {7'h00, f};
        default:            rd_mux = 8'h00;
      endcase
    end
  endfunction

  assign raw = {drive_current_pin_i, gate_settled_i, spi_sdi_i,
                spi_sclk_i, spi_cs_n_i};

  // pin synchronisers: a change counts once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < NS; g = g + 1) begin : g_sync
      always @(posedge clock_i) begin
        if (srst_i) begin
          s1_q[g]        <= (g == 0);
          s2_q[g]        <= (g == 0);
          s3_q[g]        <= (g == 0);
          filt_q[g]      <= (g == 0);
          filt_prev_q[g] <= (g == 0);
        end else begin
          s1_q[g]        <= raw[g];
          s2_q[g]        <= s1_q[g];
          s3_q[g]        <= s2_q[g];
          if (s2_q[g] == s3_q[g])
            filt_q[g] <= s3_q[g];
          filt_prev_q[g] <= filt_q[g];
        end
      end
    end
  endgenerate

  assign cs_n        = filt_q[0];
  assign sclk_rise   = filt_q[1] & ~filt_prev_q[1] & ~cs_n;
  assign sclk_fall   = ~filt_q[1] & filt_prev_q[1] & ~cs_n;
  assign cs_fall     = ~cs_n & filt_prev_q[0];
  assign cs_rise     = cs_n & ~filt_prev_q[0];
  assign rx_addr     = shift_q[14:8];
  // partial or overlong frames are dropped whole
  assign frame_ok    = cs_rise && bit_cnt_q == `SAC_FRAME_BITS;
  assign do_write    = frame_ok && !shift_q[`SAC_RW_BIT];
  assign read_status = frame_ok && shift_q[`SAC_RW_BIT] &&
                       rx_addr == `SAC_ADDR_STATUS;

  // serial shifter: sample on rising sclk, present on falling sclk
  always @(posedge clock_i) begin
    if (srst_i) begin
      shift_q      <= 16'h0000;
      rd_q         <= 8'h00;
      bit_cnt_q    <= 5'h00;
      spi_sdo_o    <= 1'b0;
      spi_sdo_oe_o <= 1'b0;
    end else begin
      spi_sdo_oe_o <= ~cs_n;
      // a deselected port shows a quiet low, not the last data bit
      if (cs_n)
        spi_sdo_o <= 1'b0;
      else if (cs_fall) begin
        bit_cnt_q <= 5'h00;
        spi_sdo_o <= 1'b0;
      end else if (sclk_rise) begin
        shift_q <= {shift_q[14:0], filt_q[2]};
        if (bit_cnt_q != 5'h1f)
          bit_cnt_q <= bit_cnt_q + 5'h01;
        // address complete after the eighth bit: latch read data
        if (bit_cnt_q == `SAC_CMD_BITS - 5'h01)
          rd_q <= rd_mux({shift_q[5:0], filt_q[2]}, ctrl_q, hs_drv_q,
                         ls_drv_q, gate_fault_o);
      end else if (sclk_fall && bit_cnt_q >= `SAC_CMD_BITS &&
                   bit_cnt_q < `SAC_FRAME_BITS) begin
        spi_sdo_o <= rd_q[7];
        rd_q      <= {rd_q[6:0], 1'b0};
      end
    end
  end

  // amplifier control register, written when a whole frame ends
  always @(posedge clock_i) begin
    if (srst_i)
      ctrl_q <= `SAC_CTRL_RST;
    else if (do_write && rx_addr == `SAC_ADDR_CTRL)
      ctrl_q <= shift_q[7:0];
  end

  // drive current settings; pin variants ignore serial writes
  always @(posedge clock_i) begin
    if (srst_i) begin
      hs_drv_q <= `SAC_DRIVE_RST;
      ls_drv_q <= `SAC_DRIVE_RST;
    end else if (SERIAL_VARIANT == 0) begin
      hs_drv_q <= {filt_q[7:4], filt_q[7:4]};
      ls_drv_q <= {filt_q[7:4], filt_q[7:4]};
    end else if (do_write) begin
      if (rx_addr == `SAC_ADDR_HS_DRIVE)
        hs_drv_q <= shift_q[7:0];
      if (rx_addr == `SAC_ADDR_LS_DRIVE)
        ls_drv_q <= shift_q[7:0];
    end
  end

  // field outputs straight from flops, one cycle behind the register
  always @(posedge clock_i) begin
    if (srst_i) begin
      sample_hold_enable_o       <= 1'b0;
      blanking_source_select_o   <= 1'b0;
      blanking_length_o          <= 3'h0;
      reference_divider_select_o <= 1'b0;
      amplifier_gain_code_o      <= 2'h1;
      hs_source_drive_current_o  <= 4'h0;
      hs_sink_drive_current_o    <= 4'h0;
      ls_source_drive_current_o  <= 4'h0;
      ls_sink_drive_current_o    <= 4'h0;
    end else begin
      sample_hold_enable_o       <= ctrl_q[`SAC_SH_EN_BIT];
      blanking_source_select_o   <= ctrl_q[`SAC_BLK_SEL_BIT];
      blanking_length_o          <= ctrl_q[`SAC_BLK_MSB:`SAC_BLK_LSB];
      reference_divider_select_o <= ctrl_q[`SAC_DIV_BIT];
      amplifier_gain_code_o      <= ctrl_q[`SAC_GAIN_MSB:`SAC_GAIN_LSB];
      hs_source_drive_current_o  <= hs_drv_q[7:4];
      hs_sink_drive_current_o    <= hs_drv_q[3:0];
      ls_source_drive_current_o  <= ls_drv_q[7:4];
      ls_sink_drive_current_o    <= ls_drv_q[3:0];
    end
  end

  // sticky gate fault; a new fault beats the read-clear
  always @(posedge clock_i) begin
    if (srst_i)
      gate_fault_o <= 1'b0;
    else if (fault_evt)
      gate_fault_o <= 1'b1;
    else if (read_status)
      gate_fault_o <= 1'b0;
  end

  // timer works off the live register so blanking follows writes at once
  sac_blank_timer #(
    .DRV_CYCLES     (DRV_CYCLES)
  ) u_blank (
    .clock_i        (clock_i),
    .srst_i         (srst_i),
    .hb1_switch_i   (hb1_switch_i),
    .hb2_switch_i   (hb2_switch_i),
    .source_sel_i   (ctrl_q[`SAC_BLK_SEL_BIT]),
    .length_code_i  (ctrl_q[`SAC_BLK_MSB:`SAC_BLK_LSB]),
    .gate_settled_i (filt_q[3]),
    .blanking_o     (blanking_o),
    .amp_update_o   (amp_update_o),
    .gate_fault_o   (fault_evt)
  );
endmodule // sac_top
`default_nettype wire

// ### sac_top_props.sv
// port level properties of the shunt amplifier control block
`timescale 1ns/1ps
`default_nettype none
module sac_top_props #(
  parameter DRV_CYCLES = 16
) (
  input wire logic       clock_i,
  input wire logic       srst_i,
  input wire logic       spi_cs_n_i,
  input wire logic       spi_sdo_o,
  input wire logic       spi_sdo_oe_o,
  input wire logic       hb1_switch_i,
  input wire logic       hb2_switch_i,
  input wire logic       sample_hold_enable_o,
  input wire logic       blanking_source_select_o,
  input wire logic [2:0] blanking_length_o,
  input wire logic       reference_divider_select_o,
  input wire logic [1:0] amplifier_gain_code_o,
  input wire logic       blanking_o,
  input wire logic       amp_update_o,
  input wire logic       gate_fault_o
);
  logic [15:0] run_q;
  wire  [7:0]  fld_w = {sample_hold_enable_o, blanking_source_select_o,
    blanking_length_o, reference_divider_select_o, amplifier_gain_code_o};
  // retrigger is not modelled: a restart mid-run breaks the length check
  wire         sel_w = blanking_source_select_o ? hb2_switch_i : hb1_switch_i;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  sequence idle_s; spi_cs_n_i [*8]; endsequence
  sequence start_s; !blanking_o ##1 blanking_o; endsequence
  // cycles spent in the current blanking run
  always_ff @(posedge clock_i)
    if (srst_i)
      run_q <= 16'h0000;
    else
      run_q <= blanking_o ? run_q + 16'h0001 : 16'h0000;
  gain_reset_a: assert property (
    $fell(srst_i) |-> amplifier_gain_code_o == 2'h1)
    else $error("gain not at reset value");
  fields_reset_a: assert property (
    $fell(srst_i) |-> fld_w[7:2] == 6'h00)
    else $error("control fields not cleared by reset");
  update_inv_a: assert property (amp_update_o != blanking_o)
    else $error("amplifier update not inverse of blanking");
  blank_start_a: assert property (start_s |-> $past(sel_w))
    else $error("blanking began without a selected event");
  blank_len_a: assert property ($fell(blanking_o) |->
    run_q == DRV_CYCLES * (blanking_length_o + 1) / 8)
    else $error("blanking run has wrong length");
  fault_time_a: assert property (
    // timer flag then sticky flag: two flops behind the last count
    $rose(gate_fault_o) |-> $past(hb1_switch_i, DRV_CYCLES + 2))
    else $error("gate fault not one drive time after event");
  hold_fields_a: assert property (idle_s |=> $stable(fld_w))
    else $error("control fields moved without a frame");
  sdo_idle_a: assert property (
    idle_s |-> !spi_sdo_oe_o && !spi_sdo_o)
    else $error("serial output driven while deselected");
endmodule // sac_top_props
bind sac_top sac_top_props #(.DRV_CYCLES(DRV_CYCLES)) i_props (
  .clock_i(clock_i), .srst_i(srst_i), .spi_cs_n_i(spi_cs_n_i),
  .spi_sdo_o(spi_sdo_o), .spi_sdo_oe_o(spi_sdo_oe_o),
  .hb1_switch_i(hb1_switch_i), .hb2_switch_i(hb2_switch_i),
  .sample_hold_enable_o(sample_hold_enable_o),
  .blanking_source_select_o(blanking_source_select_o),
  .blanking_length_o(blanking_length_o),
  .reference_divider_select_o(reference_divider_select_o),
  .amplifier_gain_code_o(amplifier_gain_code_o),
  .blanking_o(blanking_o), .amp_update_o(amp_update_o),
  .gate_fault_o(gate_fault_o));
`default_nettype wire

// ### sac_host_model.sv
// host model: serial port master sending one frame per call
`timescale 1ns/1ps
`default_nettype none
module sac_host_model (
  input  wire logic clock_i,
  input  wire logic spi_sdo_i,
  input  wire logic spi_sdo_oe_i,
  output var  logic spi_sclk_o,
  output var  logic spi_sdi_o,
  output var  logic spi_cs_n_o
);
  logic last_q = 1'b0;
  // a released line shows the inverse of its last level, never a hold
  wire  line_w = spi_sdo_oe_i ? spi_sdo_i : ~last_q;
  always @(posedge clock_i)
    if (spi_sdo_oe_i)
      last_q <= spi_sdo_i;
  initial begin
    spi_sclk_o = 1'b0;
    spi_sdi_o  = 1'b0;
    spi_cs_n_o = 1'b1;
  end
  // 8 clocks per phase keeps the pin edges clear of the synchroniser
  task automatic xfer(input logic [15:0] f, output logic [7:0] rd);
    @(negedge clock_i);
    spi_cs_n_o = 1'b0;
    repeat (4) @(negedge clock_i);
    for (int i = 15; i >= 0; i--) begin
      spi_sdi_o = f[i];
      repeat (8) @(negedge clock_i);
      if (i < 8)
        rd[i] = line_w;
      spi_sclk_o = 1'b1;
      repeat (8) @(negedge clock_i);
      spi_sclk_o = 1'b0;
    end
    repeat (8) @(negedge clock_i);
    spi_cs_n_o = 1'b1;
    spi_sdi_o  = ~f[0];
    repeat (10) @(negedge clock_i);
  endtask
endmodule // sac_host_model
`default_nettype wire

// ### sac_top_tb.sv
// testbench: register access, blanking and gate fault sequences
`timescale 1ns/1ps
`default_nettype none
module sac_top_tb;
  localparam int DRV = 16;
  logic       clock_i = 1'b0;
  logic       srst_i  = 1'b1;
  logic       hb1 = 1'b0, hb2 = 1'b0, settled = 1'b1;
  logic       sclk, sdi, csn, sdo, oe, sh, sel, dv, blank, upd, fault;
  logic [2:0] len;
  logic [1:0] gn;
  logic [3:0] hss, hsk, lss, lsk;
  logic [3:0] pin = 4'h0, pa, pb, pc, pd;
  logic [7:0] val [8] = '{8'h80, 8'h40, 8'h38, 8'h04, 8'h00, 8'h02,
                          8'h03, 8'hff};
  int         errors = 0, tests_run = 0, cyc = 0;
  sac_top #(.SERIAL_VARIANT(1), .DRV_CYCLES(DRV)) i_dut (
    .clock_i(clock_i), .srst_i(srst_i), .spi_sclk_i(sclk),
    .spi_sdi_i(sdi), .spi_cs_n_i(csn), .spi_sdo_o(sdo),
    .spi_sdo_oe_o(oe), .drive_current_pin_i(4'h0),
    .gate_settled_i(settled), .hb1_switch_i(hb1), .hb2_switch_i(hb2),
    .sample_hold_enable_o(sh), .blanking_source_select_o(sel),
    .blanking_length_o(len), .reference_divider_select_o(dv),
    .amplifier_gain_code_o(gn), .hs_source_drive_current_o(hss),
    .hs_sink_drive_current_o(hsk), .ls_source_drive_current_o(lss),
    .ls_sink_drive_current_o(lsk), .blanking_o(blank),
    .amp_update_o(upd), .gate_fault_o(fault));
  sac_host_model i_host (
    .clock_i(clock_i), .spi_sdo_i(sdo), .spi_sdo_oe_i(oe),
    .spi_sclk_o(sclk), .spi_sdi_o(sdi), .spi_cs_n_o(csn));
  // pin-configured variant: drive code comes from the pins only
  sac_top #(.SERIAL_VARIANT(0), .DRV_CYCLES(DRV)) i_dut_pin (
    .clock_i(clock_i), .srst_i(srst_i), .spi_sclk_i(1'b0),
    .spi_sdi_i(1'b0), .spi_cs_n_i(1'b1), .spi_sdo_o(),
    .spi_sdo_oe_o(), .drive_current_pin_i(pin),
    .gate_settled_i(1'b1), .hb1_switch_i(1'b0), .hb2_switch_i(1'b0),
    .sample_hold_enable_o(), .blanking_source_select_o(),
    .blanking_length_o(), .reference_divider_select_o(),
    .amplifier_gain_code_o(), .hs_source_drive_current_o(pa),
    .hs_sink_drive_current_o(pb), .ls_source_drive_current_o(pc),
    .ls_sink_drive_current_o(pd), .blanking_o(), .amp_update_o(),
    .gate_fault_o());
  initial begin
    forever #5 clock_i = ~clock_i;
  end
  task automatic end_of_test;
    if (errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // a hang counts as a mismatch and closes the run
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      end_of_test;
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] x;
    i_host.xfer({1'b0, a, d}, x);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] x;
    i_host.xfer({1'b1, a, 8'h00}, x);
    chk(x, exp);
  endtask
  // one-cycle switching event on either half-bridge
  task automatic pulse(input logic h1, input logic h2);
    @(negedge clock_i);
    hb1 = h1;
    hb2 = h2;
    @(negedge clock_i);
    hb1 = 1'b0;
    hb2 = 1'b0;
  endtask
  task automatic blk(input logic h1, input logic h2, input int exp);
    int n;
    n = 0;
    pulse(h1, h2);
    // the first window cycle is already up when pulse returns
    repeat (40) begin
      if (blank === 1'b1 && upd === 1'b0)
        n++;
      @(negedge clock_i);
    end
    chk(8'(n), 8'(exp));
  endtask
  initial begin
    repeat (20) @(negedge clock_i);
    srst_i = 1'b0;
    repeat (4) @(negedge clock_i);
    rd(7'h0d, 8'h01);
    chk({sh, sel, len, dv, gn}, 8'h01);
    foreach (val[k]) begin
      wr(7'h0d, val[k]);
      rd(7'h0d, val[k]);
      chk({sh, sel, len, dv, gn}, val[k]);
    end
    // reset in mid-run must bring back the default over a written value
    srst_i = 1'b1;
    repeat (2) @(negedge clock_i);
    srst_i = 1'b0;
    repeat (4) @(negedge clock_i);
    rd(7'h0d, 8'h01);
    chk({sh, sel, len, dv, gn}, 8'h01);
    for (int c = 0; c < 8; c++) begin
      wr(7'h0d, {2'h0, 3'(c), 3'h1});
      blk(1'b1, 1'b0, c == 0 ? 0 : DRV * (c + 1) / 8);
    end
    blk(1'b0, 1'b1, 0);
    wr(7'h0d, 8'h48);
    blk(1'b1, 1'b0, 0);
    blk(1'b0, 1'b1, DRV * 2 / 8);
    wr(7'h0e, 8'h5a);
    chk({hss, hsk}, 8'h5a);
    wr(7'h0f, 8'hc3);
    chk({lss, lsk}, 8'hc3);
    pin = 4'ha;
    repeat (8) @(negedge clock_i);
    chk({pa, pb}, 8'haa);
    chk({pc, pd}, 8'haa);
    rd(7'h20, 8'h00);
    settled = 1'b0;
    // the low level must be through the synchroniser before the event
    repeat (6) @(negedge clock_i);
    pulse(1'b1, 1'b0);
    repeat (DRV - 2) @(negedge clock_i);
    chk({7'h00, fault}, 8'h00);
    repeat (4) @(negedge clock_i);
    chk({7'h00, fault}, 8'h01);
    settled = 1'b1;
    rd(7'h01, 8'h01);
    chk({7'h00, fault}, 8'h00);
    end_of_test;
  end
endmodule // sac_top_tb
`default_nettype wire
